/* File: csbia_pkg.sv */
// constants and types shared by the core register bank
`default_nettype none
package csbia_pkg;
  // register indices; the bus byte address is four times the index
  localparam logic [3:0] IDX_PORT0 = 4'h0;
  localparam logic [3:0] IDX_PORT1 = 4'h1;
  localparam logic [3:0] IDX_PC_LOW = 4'h2;
  localparam logic [3:0] IDX_FLAGS = 4'h3;
  localparam logic [3:0] IDX_PTR0 = 4'h4;
  localparam logic [3:0] IDX_PTR0_HI = 4'h5;
  localparam logic [3:0] IDX_PTR1 = 4'h6;
  localparam logic [3:0] IDX_PTR1_HI = 4'h7;
  localparam logic [3:0] IDX_BANK = 4'h8;
  localparam logic [3:0] IDX_WACC = 4'h9;
  localparam logic [3:0] IDX_PC_HIGH = 4'ha;
  // flag bit positions
  localparam int FLG_EXPIRY = 4;
  localparam int FLG_SLEEP = 3;
  localparam int FLG_NULL = 2;
  localparam int FLG_NIBBLE = 1;
  localparam int FLG_CARRY = 0;
  // reset values and writable masks
  localparam logic [7:0] FLAGS_POR = 8'h18;
  localparam logic [7:0] FLAGS_WMASK = 8'h07;
  localparam logic [7:0] BANK_MASK = 8'h3f;
  localparam logic [7:0] PC_HIGH_MASK = 8'h7f;
  // pointer values that name the indirect ports themselves
  localparam logic [15:0] PORT0_ADDR = 16'h0000;
  localparam logic [15:0] PORT1_ADDR = 16'h0001;
  localparam int PROG_BIT = 15;
  // power-up delay
  localparam int unsigned PUD_MS = 64;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PUD_CYC = PUD_MS * CLK_MHZ * 1000;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ADD = 3'h1,
    OP_SUB = 3'h2,
    OP_RL = 3'h3,
    OP_RR = 3'h4,
    OP_LOGIC = 3'h5
  } csbia_op_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WACC = 6'h02,
    ST_RACC = 6'h04,
    ST_MEM = 6'h08,
    ST_BRESP = 6'h10,
    ST_RRESP = 6'h20
  } csbia_st_t;
endpackage
`default_nettype wire

/* File: csbia_bank.sv */
// core register bank with indirect ports, flags and reset control
//
// Register access over AXI4-Lite was chosen for this implementation.
`default_nettype none
// Overview of operation
// - port 0 accesses act on the location held in pointer 0.
// - port 1 accesses act on the location held in pointer 1.
// - program counter low byte is directly readable and writable.
// - expiry flag set by power-up, kick or sleep; cleared by watchdog timeout.
// - sleep flag set by power-up or kick; cleared by sleep.
// - null flag is 1 exactly when an add, subtract or logic result is zero; rotates leave it.
// - nibble carry is the carry out of bit 3 on add and subtract.
// - carry flag is the carry out of bit 7 on add and subtract.
// - subtract adds the two's complement, so carry means no borrow.
// - rotates load carry from the bit shifted out of the source.
// - power-on or brown-out clears null, nibble and carry flags.
// - power-on or brown-out sets expiry and sleep flags; others by cause.
// - pointer 0 is 16 bits, resets to zero, bytes separately addressable.
// - pointer 1 is 16 bits, resets to zero, bytes separately addressable.
// - bank select holds six bits giving the direct address top bits.
// - high latch holds seven bits, reset zero, moved into the counter.
// - every listed cause, including programming exit, resets the device.
// - leaving programming mode acts exactly like a power-on reset.
// - optional power-up delay lengthens reset after power-on or brown-out.
// - pointer naming a port: indirect read gives zero, write is dropped.
// - pointer top bit set reads program memory low byte, no writes.
module csbia_bank #(
  parameter int unsigned PUD_CYCLES = csbia_pkg::PUD_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // arithmetic events from the execution core
  input wire csbia_pkg::csbia_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  // power and reset events
  input wire logic watchdog_kick_op,
  input wire logic sleep_op,
  input wire logic watchdog_timeout,
  input wire logic watchdog_reset,
  input wire logic reset_op,
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  input wire logic prog_mode_exit,
  input wire logic brownout_reset,
  input wire logic external_clear_pin_n,
  input wire logic power_up_delay_en,
  output logic core_reset,
  // program counter
  input wire logic pc_load_valid,
  input wire logic [14:0] pc_load_value,
  output logic pc_jump,
  output logic [14:0] pc_jump_value,
  // register values towards the core
  output logic [7:0] flags_out,
  output logic [5:0] bank_addr_high,
  output logic [7:0] working_acc_out,
  // memory behind the indirect ports
  output logic mem_req,
  output logic mem_prog,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  import csbia_pkg::*;

  typedef struct packed {
    csbia_st_t st;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic mreq;
    logic mprog;
    logic mwe;
    logic [15:0] maddr;
    logic [7:0] mwdata;
    logic [7:0] pc_low;
    logic [7:0] flags;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [7:0] bank;
    logic [7:0] wacc;
    logic [7:0] pc_high;
    logic jump;
    logic [14:0] jump_val;
    logic clr_s1;
    logic clr_s2;
    logic dly_run;
    logic [22:0] dly_cnt;
    logic core_rst;
  } csbia_state_t;

  localparam csbia_state_t S_RST = '{st: ST_IDLE, flags: FLAGS_POR,
    clr_s1: 1'b1, clr_s2: 1'b1, dly_run: 1'b1, core_rst: 1'b1,
    default: '0};
  localparam logic [22:0] DLY_LAST = 23'(PUD_CYCLES - 1);

  csbia_state_t s_reg;
  csbia_state_t s_next;
  logic por_ev;
  logic rst_ev;
  logic aw_ok;
  logic ar_ok;
  logic [3:0] aw_idx;
  logic [3:0] ar_idx;
  logic [15:0] wptr;
  logic [15:0] rptr;
  logic [7:0] opb;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] nib;

  always_comb begin
    s_next = s_reg;
    s_next.jump = 1'b0;
    s_next.clr_s1 = external_clear_pin_n;
    s_next.clr_s2 = s_reg.clr_s1;
    // programming exit joins the power-on class
    por_ev = brownout_reset | prog_mode_exit;
    rst_ev = por_ev | watchdog_reset | reset_op | stack_overflow |
      stack_underflow | !s_reg.clr_s2;
    aw_idx = awaddr[5:2];
    ar_idx = araddr[5:2];
    aw_ok = (awaddr[31:6] == 26'h0) && (awaddr[1:0] == 2'h0);
    ar_ok = (araddr[31:6] == 26'h0) && (araddr[1:0] == 2'h0);
    // each port follows its own pointer
    wptr = (aw_idx == IDX_PORT0) ? s_reg.ptr0 : s_reg.ptr1;
    rptr = (ar_idx == IDX_PORT0) ? s_reg.ptr0 : s_reg.ptr1;
    opb = (alu_op == OP_SUB) ? ~alu_b : alu_b;
    cin = (alu_op == OP_SUB);
    sum9 = {1'b0, alu_a} + {1'b0, opb} + {8'h0, cin};
    nib = {1'b0, alu_a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};

    case (s_reg.st)
      ST_IDLE: begin
        // write wins when both directions arrive together
        if (awvalid && wvalid) begin
          s_next.awready = 1'b1;
          s_next.wready = 1'b1;
          s_next.st = ST_WACC;
        end else if (arvalid) begin
          s_next.arready = 1'b1;
          s_next.st = ST_RACC;
        end
      end
      ST_WACC: begin
        s_next.awready = 1'b0;
        s_next.wready = 1'b0;
        s_next.bvalid = 1'b1;
        s_next.bresp = RESP_OKAY;
        s_next.st = ST_BRESP;
        if (!aw_ok) begin
          s_next.bresp = RESP_SLVERR;
        end else begin
          case (aw_idx)
            IDX_PORT0, IDX_PORT1: begin
              // port-to-port and program writes are dropped
              if (wstrb[0] && wptr != PORT0_ADDR && wptr != PORT1_ADDR &&
                  !wptr[PROG_BIT]) begin
                s_next.mreq = 1'b1;
                s_next.mwe = 1'b1;
                s_next.mprog = 1'b0;
                s_next.maddr = wptr;
                s_next.mwdata = wdata[7:0];
                s_next.bvalid = 1'b0;
                s_next.st = ST_MEM;
              end
            end
            IDX_PC_LOW: begin
              // writing the low byte moves the latch in too
              if (wstrb[0]) begin
                s_next.pc_low = wdata[7:0];
                s_next.jump = 1'b1;
                s_next.jump_val = {s_reg.pc_high[6:0], wdata[7:0]};
              end
            end
            IDX_FLAGS: begin
              // only the three result flags take writes
              if (wstrb[0]) begin
                s_next.flags = (s_reg.flags & ~FLAGS_WMASK) |
                  (wdata[7:0] & FLAGS_WMASK);
              end
            end
            IDX_PTR0: begin
              // byte lanes reach the two halves
              if (wstrb[0]) s_next.ptr0[7:0] = wdata[7:0];
              if (wstrb[1]) s_next.ptr0[15:8] = wdata[15:8];
            end
            IDX_PTR0_HI: begin
              if (wstrb[0]) s_next.ptr0[15:8] = wdata[7:0];
            end
            IDX_PTR1: begin
              // byte lanes reach the two halves
              if (wstrb[0]) s_next.ptr1[7:0] = wdata[7:0];
              if (wstrb[1]) s_next.ptr1[15:8] = wdata[15:8];
            end
            IDX_PTR1_HI: begin
              if (wstrb[0]) s_next.ptr1[15:8] = wdata[7:0];
            end
            IDX_BANK: begin
              if (wstrb[0]) s_next.bank = wdata[7:0] & BANK_MASK;
            end
            IDX_WACC: begin
              if (wstrb[0]) s_next.wacc = wdata[7:0];
            end
            IDX_PC_HIGH: begin
              if (wstrb[0]) s_next.pc_high = wdata[7:0] & PC_HIGH_MASK;
            end
            default: s_next.bresp = RESP_SLVERR;
          endcase
        end
      end
      ST_RACC: begin
        s_next.arready = 1'b0;
        s_next.rvalid = 1'b1;
        s_next.rresp = RESP_OKAY;
        s_next.rdata = 32'h0;
        s_next.st = ST_RRESP;
        if (!ar_ok) begin
          s_next.rresp = RESP_SLVERR;
        end else begin
          case (ar_idx)
            IDX_PORT0, IDX_PORT1: begin
              // a port naming a port reads zero
              if (rptr != PORT0_ADDR && rptr != PORT1_ADDR) begin
                s_next.mreq = 1'b1;
                s_next.mwe = 1'b0;
                s_next.mprog = rptr[PROG_BIT];
                s_next.maddr = rptr[PROG_BIT] ?
                  {1'b0, rptr[14:0]} : rptr;
                s_next.rvalid = 1'b0;
                s_next.st = ST_MEM;
              end
            end
            IDX_PC_LOW: s_next.rdata = {24'h0, s_reg.pc_low};
            IDX_FLAGS: s_next.rdata = {24'h0, s_reg.flags};
            IDX_PTR0: s_next.rdata = {16'h0, s_reg.ptr0};
            IDX_PTR0_HI: s_next.rdata = {24'h0, s_reg.ptr0[15:8]};
            IDX_PTR1: s_next.rdata = {16'h0, s_reg.ptr1};
            IDX_PTR1_HI: s_next.rdata = {24'h0, s_reg.ptr1[15:8]};
            IDX_BANK: s_next.rdata = {24'h0, s_reg.bank};
            IDX_WACC: s_next.rdata = {24'h0, s_reg.wacc};
            IDX_PC_HIGH: s_next.rdata = {24'h0, s_reg.pc_high};
            default: s_next.rresp = RESP_SLVERR;
          endcase
        end
      end
      ST_MEM: begin
        if (mem_ack) begin
          s_next.mreq = 1'b0;
          if (s_reg.mwe) begin
            s_next.bvalid = 1'b1;
            s_next.st = ST_BRESP;
          end else begin
            // only the low byte of a program word is visible
            s_next.rdata = {24'h0, mem_rdata[7:0]};
            s_next.rvalid = 1'b1;
            s_next.st = ST_RRESP;
          end
        end
      end
      ST_BRESP: begin
        if (bready) begin
          s_next.bvalid = 1'b0;
          s_next.st = ST_IDLE;
        end
      end
      ST_RRESP: begin
        if (rready) begin
          s_next.rvalid = 1'b0;
          s_next.st = ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase

    // the core's own counter updates follow the low byte
    if (pc_load_valid) s_next.pc_low = pc_load_value[7:0];

    // core results override a software write in the same cycle
    case (alu_op)
      OP_ADD, OP_SUB: begin
        s_next.wacc = sum9[7:0];
        s_next.flags[FLG_NULL] = (sum9[7:0] == 8'h0);
        // nibble carry, inverted borrow on subtract
        s_next.flags[FLG_NIBBLE] = nib[4];
        // carry out of the top bit
        s_next.flags[FLG_CARRY] = sum9[8];
      end
      OP_RL: begin
        // carry takes the bit shifted out
        s_next.wacc = {alu_a[6:0], s_reg.flags[FLG_CARRY]};
        s_next.flags[FLG_CARRY] = alu_a[7];
      end
      OP_RR: begin
        s_next.wacc = {s_reg.flags[FLG_CARRY], alu_a[7:1]};
        s_next.flags[FLG_CARRY] = alu_a[0];
      end
      OP_LOGIC: begin
        // logic results only touch the null flag
        s_next.wacc = alu_a;
        s_next.flags[FLG_NULL] = (alu_a == 8'h0);
      end
      default: ;
    endcase

    // timeout placed last so it wins over a kick
    if (watchdog_kick_op) begin
      s_next.flags[FLG_EXPIRY] = 1'b1;
      s_next.flags[FLG_SLEEP] = 1'b1;
    end
    if (sleep_op) begin
      s_next.flags[FLG_EXPIRY] = 1'b1;
      s_next.flags[FLG_SLEEP] = 1'b0;
    end
    if (watchdog_timeout) s_next.flags[FLG_EXPIRY] = 1'b0;

    // reset actions; flags survive non power-on causes, except that a watchdog reset clears expiry
    if (rst_ev) begin
      s_next.pc_low = 8'h0;
      s_next.ptr0 = 16'h0;
      s_next.ptr1 = 16'h0;
      s_next.bank = 8'h0;
      s_next.wacc = 8'h0;
      s_next.pc_high = 8'h0;
      // a watchdog reset marks its cause
      if (watchdog_reset) s_next.flags[FLG_EXPIRY] = 1'b0;
      // power-on class restores the flag defaults
      if (por_ev) s_next.flags = FLAGS_POR;
    end

    // delay counts only while enabled, then releases reset
    if (s_reg.dly_run) begin
      if (!power_up_delay_en || s_reg.dly_cnt == DLY_LAST) begin
        s_next.dly_run = 1'b0;
      end else begin
        s_next.dly_cnt = s_reg.dly_cnt + 23'h1;
      end
    end
    if (por_ev) begin
      s_next.dly_run = 1'b1;
      s_next.dly_cnt = 23'h0;
    end
    s_next.core_rst = rst_ev | s_next.dly_run;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= S_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bresp = s_reg.bresp;
  assign bvalid = s_reg.bvalid;
  assign arready = s_reg.arready;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign rvalid = s_reg.rvalid;
  assign core_reset = s_reg.core_rst;
  assign pc_jump = s_reg.jump;
  assign pc_jump_value = s_reg.jump_val;
  assign flags_out = s_reg.flags;
  assign bank_addr_high = s_reg.bank[5:0];
  assign working_acc_out = s_reg.wacc;
  assign mem_req = s_reg.mreq;
  assign mem_prog = s_reg.mprog;
  assign mem_we = s_reg.mwe;
  assign mem_addr = s_reg.maddr;
  assign mem_wdata = s_reg.mwdata;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence rd_port0_self;
    s_reg.st == ST_RACC && ar_ok && ar_idx == IDX_PORT0 &&
      s_reg.ptr0 == PORT1_ADDR;
  endsequence
  sequence zero_answer;
    s_reg.rvalid && s_reg.rdata == 32'h0 && !s_reg.mreq;
  endsequence
  port_self_zero_a: assert property (rd_port0_self |=> zero_answer)
    else $error("port naming a port did not read zero");

  port0_mem_addr_a: assert property (
    (s_reg.st == ST_RACC && ar_ok && ar_idx == IDX_PORT0 &&
     s_reg.ptr0 > PORT1_ADDR && !rst_ev) |=>
    s_reg.mreq && !s_reg.mwe && s_reg.mprog == $past(s_reg.ptr0[15]) &&
    s_reg.maddr == {1'b0, $past(s_reg.ptr0[14:0])})
    else $error("port 0 read went to the wrong address");

  port1_mem_write_a: assert property (
    (s_reg.st == ST_WACC && aw_ok && aw_idx == IDX_PORT1 && wstrb[0] &&
     s_reg.ptr1 > PORT1_ADDR && !s_reg.ptr1[15]) |=>
    s_reg.mreq && s_reg.mwe && s_reg.maddr == $past(s_reg.ptr1) &&
    s_reg.mwdata == $past(wdata[7:0]) ##1 s_reg.mreq || s_reg.bvalid)
    else $error("port 1 write not carried to memory");

  prog_no_write_a: assert property (
    (s_reg.st == ST_WACC && aw_ok && aw_idx == IDX_PORT0 &&
     s_reg.ptr0[15]) |=> s_reg.bvalid && !s_reg.mreq)
    else $error("program memory write was not dropped");

  add_flags_a: assert property (
    (alu_op == OP_ADD && !rst_ev) |=>
    {s_reg.flags[FLG_CARRY], s_reg.wacc} ==
      {1'b0, $past(alu_a)} + {1'b0, $past(alu_b)} &&
    s_reg.flags[FLG_NIBBLE] ==
      ({1'b0, $past(alu_a[3:0])} + {1'b0, $past(alu_b[3:0])} > 5'h0f))
    else $error("add result or carries wrong");

  sub_borrow_a: assert property (
    (alu_op == OP_SUB && !rst_ev) |=>
    s_reg.flags[FLG_CARRY] == ($past(alu_a) >= $past(alu_b)) &&
    s_reg.flags[FLG_NULL] == ($past(alu_a) == $past(alu_b)))
    else $error("subtract borrow or null flag wrong");

  rotate_carry_a: assert property (
    (alu_op == OP_RL && !rst_ev) |=>
    s_reg.flags[FLG_CARRY] == $past(alu_a[7]) &&
    s_reg.wacc[0] == $past(s_reg.flags[FLG_CARRY]))
    else $error("rotate left carry wrong");

  sleep_flags_a: assert property (
    (sleep_op && !watchdog_kick_op && !watchdog_timeout && !rst_ev) |=>
    !s_reg.flags[FLG_SLEEP] && s_reg.flags[FLG_EXPIRY])
    else $error("sleep did not update the power flags");

  timeout_flag_a: assert property (
    (watchdog_timeout && !por_ev) |=> !s_reg.flags[FLG_EXPIRY])
    else $error("watchdog timeout did not clear expiry flag");

  por_flags_a: assert property (
    (prog_mode_exit || brownout_reset) |=>
    s_reg.flags[4:0] == FLAGS_POR[4:0] && s_reg.ptr0 == 16'h0)
    else $error("power-on class reset state wrong");

  sequence delayed_por;
    brownout_reset && power_up_delay_en;
  endsequence
  por_delay_hold_a: assert property (
    delayed_por ##1 power_up_delay_en [*7] |=> s_reg.core_rst)
    else $error("power-up delay released reset too early");

  bank_mask_a: assert property (
    (s_reg.st == ST_WACC && aw_ok && aw_idx == IDX_BANK && !rst_ev) |=>
    s_reg.bank[7:6] == 2'h0 &&
    (!$past(wstrb[0]) || s_reg.bank[5:0] == $past(wdata[5:0])) ##1
    s_reg.bank[7:6] == 2'h0)
    else $error("bank select upper bits not zero");
endmodule
`default_nettype wire

/* File: csbia_mem_model.sv */
// memory model behind the indirect ports of the register bank
`default_nettype none
module csbia_mem_model (
  // clock and answer delay
  input wire logic aclk,
  input wire logic [3:0] wait_cycles,
  // memory port
  input wire logic mem_req,
  input wire logic mem_prog,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ram [256];
  logic [3:0] cnt;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0;
    cnt = 4'h0;
    foreach (ram[i]) ram[i] = 8'h0;
  end
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    // data toggles between answers so a stale value never passes
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= wait_cycles) begin
        cnt <= 4'h0;
        mem_ack <= 1'b1;
        // program words carry a junk upper byte
        if (mem_prog) mem_rdata <= {8'hee, ~mem_addr[7:0]};
        else mem_rdata <= {8'hdd, ram[mem_addr[7:0]]};
        if (mem_we && !mem_prog) ram[mem_addr[7:0]] <= mem_wdata;
      end
    end
  end
endmodule
`default_nettype wire

/* File: csbia_bank_tb.sv */
// self-checking bench for the core register bank
`default_nettype none
module csbia_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csbia_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pud_en, core_reset, pc_jump, pc_ld;
  logic mem_req, mem_prog, mem_we, mem_ack;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb, wait_cycles;
  logic [1:0] bresp, rresp;
  logic [7:0] alu_a, alu_b, flags_out, working_acc_out, mem_wdata;
  logic [9:0] evt;
  logic [14:0] pc_jump_value, jump_val;
  logic [15:0] mem_addr, mem_rdata;
  logic [5:0] bank_addr_high;
  csbia_op_t alu_op;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  localparam logic [7:0] RST_FL [7] = '{8'h04, 8'h04, 8'h04, 8'h04,
    8'h18, 8'h18, 8'h18};
  csbia_bank #(.PUD_CYCLES(16)) dut_u (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .alu_op, .alu_a, .alu_b, .watchdog_kick_op(evt[8]),
    .sleep_op(evt[7]), .watchdog_timeout(evt[9]),
    .watchdog_reset(evt[0]), .reset_op(evt[1]), .stack_overflow(evt[2]),
    .stack_underflow(evt[3]), .prog_mode_exit(evt[4]),
    .brownout_reset(evt[5]), .external_clear_pin_n(~evt[6]),
    .power_up_delay_en(pud_en), .core_reset, .pc_load_valid(pc_ld),
    .pc_load_value(15'h0456), .pc_jump, .pc_jump_value, .flags_out,
    .bank_addr_high, .working_acc_out, .mem_req, .mem_prog, .mem_we,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  csbia_mem_model mem_u (.aclk, .wait_cycles, .mem_req, .mem_prog,
    .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) if (pc_jump) jump_val <= pc_jump_value;
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic hang();
    n_mismatch++;
    $display("ERROR %0t: wait ran out", $time);
    final_report();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] er);
    int k;
    @(posedge aclk);
    k = 0;
    awaddr <= {26'h0, idx, 2'h0};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 200);
    bready <= 1'b0;
    if (k == 200) hang();
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [3:0] idx, input logic [31:0] exp,
    input logic [1:0] er);
    int k;
    @(posedge aclk);
    k = 0;
    araddr <= {26'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 200);
    rready <= 1'b0;
    if (k == 200) hang();
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // one core cycle of operation and events, then the flags it leaves
  task automatic step(input csbia_op_t op, input logic [7:0] a,
    input logic [7:0] b, input logic [9:0] e, input logic [7:0] fl);
    @(posedge aclk);
    alu_op <= op;
    alu_a <= a;
    alu_b <= b;
    evt <= e;
    @(posedge aclk);
    alu_op <= OP_NONE;
    evt <= 10'h0;
    @(posedge aclk);
    #1 chk({24'h0, flags_out}, {24'h0, fl});
  endtask
  // the clear pin goes through a synchroniser, so give it time to bite
  task automatic settle();
    repeat (3) @(posedge aclk);
    n = 0;
    while (core_reset !== 1'b0 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    if (n == 200) hang();
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pud_en, pc_ld} = 8'h0;
    {awaddr, wdata, araddr, wstrb, wait_cycles} = 104'h0;
    {alu_a, alu_b, evt} = 26'h0;
    alu_op = OP_NONE;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    rd(IDX_FLAGS, 32'h18, RESP_OKAY);
    rd(IDX_PTR0, 32'h0, RESP_OKAY);
    rd(IDX_PTR1, 32'h0, RESP_OKAY);
    rd(IDX_PC_HIGH, 32'h0, RESP_OKAY);
    wr(IDX_BANK, 32'hff, 4'hf, RESP_OKAY);
    rd(IDX_BANK, 32'h3f, RESP_OKAY);
    chk({26'h0, bank_addr_high}, 32'h3f);
    wr(IDX_PC_HIGH, 32'hff, 4'hf, RESP_OKAY);
    rd(IDX_PC_HIGH, 32'h7f, RESP_OKAY);
    wr(IDX_PC_HIGH, 32'h05, 4'hf, RESP_OKAY);
    wr(IDX_PC_LOW, 32'h34, 4'hf, RESP_OKAY);
    #1 chk({17'h0, jump_val}, 32'h0534);
    rd(IDX_PC_LOW, 32'h34, RESP_OKAY);
    pc_ld <= 1'b1;
    @(posedge aclk);
    pc_ld <= 1'b0;
    rd(IDX_PC_LOW, 32'h56, RESP_OKAY);
    wr(IDX_FLAGS, 32'hff, 4'hf, RESP_OKAY);
    rd(IDX_FLAGS, 32'h1f, RESP_OKAY);
    wr(IDX_FLAGS, 32'h0, 4'hf, RESP_OKAY);
    step(OP_ADD, 8'h0f, 8'h01, 10'h0, 8'h1a);
    step(OP_ADD, 8'hff, 8'h01, 10'h0, 8'h1f);
    step(OP_SUB, 8'h05, 8'h03, 10'h0, 8'h1b);
    step(OP_SUB, 8'h03, 8'h05, 10'h0, 8'h18);
    step(OP_RL, 8'h80, 8'h00, 10'h0, 8'h19);
    step(OP_RR, 8'h02, 8'h00, 10'h0, 8'h18);
    step(OP_LOGIC, 8'h00, 8'h00, 10'h0, 8'h1c);
    step(OP_NONE, 8'h00, 8'h00, 10'h080, 8'h14);
    step(OP_NONE, 8'h00, 8'h00, 10'h100, 8'h1c);
    step(OP_NONE, 8'h00, 8'h00, 10'h200, 8'h0c);
    step(OP_NONE, 8'h00, 8'h00, 10'h080, 8'h14);
    wr(IDX_PTR0, 32'h0123, 4'h3, RESP_OKAY);
    rd(IDX_PTR0, 32'h0123, RESP_OKAY);
    wr(IDX_PORT0, 32'ha5, 4'h1, RESP_OKAY);
    wait_cycles <= 4'h3;
    rd(IDX_PORT0, 32'ha5, RESP_OKAY);
    wr(IDX_PTR1_HI, 32'h01, 4'h1, RESP_OKAY);
    wr(IDX_PTR1, 32'h23, 4'h1, RESP_OKAY);
    rd(IDX_PTR1, 32'h0123, RESP_OKAY);
    rd(IDX_PORT1, 32'ha5, RESP_OKAY);
    wait_cycles <= 4'h0;
    wr(IDX_PORT1, 32'h3c, 4'h1, RESP_OKAY);
    rd(IDX_PORT0, 32'h3c, RESP_OKAY);
    wr(IDX_PTR0, 32'h0001, 4'h3, RESP_OKAY);
    rd(IDX_PORT0, 32'h0, RESP_OKAY);
    wr(IDX_PORT0, 32'h77, 4'h1, RESP_OKAY);
    rd(IDX_PORT1, 32'h3c, RESP_OKAY);
    // pointer 1 becomes 0x0101, so port 1 reads location 1 from memory, where the dropped port 0 write left zero
    wr(IDX_PTR1, 32'h01, 4'h1, RESP_OKAY);
    rd(IDX_PORT1, 32'h0, RESP_OKAY);
    wr(IDX_PTR0, 32'h8010, 4'h3, RESP_OKAY);
    rd(IDX_PORT0, 32'hef, RESP_OKAY);
    wr(IDX_PORT0, 32'h55, 4'h1, RESP_OKAY);
    rd(4'hb, 32'h0, RESP_SLVERR);
    wr(4'hb, 32'h1, 4'hf, RESP_SLVERR);
    for (int k = 0; k < 7; k++) begin
      wr(IDX_WACC, 32'h77, 4'h1, RESP_OKAY);
      chk({24'h0, working_acc_out}, 32'h77);
      step(OP_NONE, 8'h0, 8'h0, 10'h1 << k, RST_FL[k]);
      settle();
      chk({31'h0, n < 8}, 32'h1);
      rd(IDX_WACC, 32'h0, RESP_OKAY);
    end
    pud_en <= 1'b1;
    step(OP_NONE, 8'h0, 8'h0, 10'h020, 8'h18);
    settle();
    chk({31'h0, n >= 8}, 32'h1);
    final_report();
  end
  initial begin
    repeat (100000) @(posedge aclk);
    hang();
  end
endmodule
`default_nettype wire
